// ---- pkg/rcb_cfg.svh ----
// Configuration constants for the radio configuration register bank.
`ifndef RCB_CFG_SVH
`define RCB_CFG_SVH
`define RCB_IDX_BR 4'h3
`define RCB_IDX_FLOOR 4'h4
`define RCB_IDX_FIFO 4'h5
`define RCB_IDX_REF_A 4'h6
`define RCB_IDX_PRE_A 4'h7
`define RCB_IDX_SWA_A 4'h8
`define RCB_IDX_REF_B 4'h9
`define RCB_IDX_PRE_B 4'hA
`define RCB_IDX_SWA_B 4'hB
`define RCB_IDX_RAMP 4'hC
`define RCB_IDX_CTRL 4'hF
`define RCB_FIRST_IDX 4'h3
`define RCB_NUM_REGS 13
`define RCB_RST_BR 8'h07
`define RCB_BR_MASK 8'h7F
`define RCB_RST_FLOOR 8'h0C
`define RCB_RST_FIFO 8'h0F
`define RCB_RST_REF_A 8'h00
`define RCB_RST_PRE_A 8'h00
`define RCB_RST_SWA_A 8'h00
`define RCB_RST_REF_B 8'h00
`define RCB_RST_PRE_B 8'h62
`define RCB_RST_SWA_B 8'h00
`define RCB_RST_RAMP 8'h38
`define RCB_RST_CTRL 8'h00
`define RCB_RAMP_HI 4
`define RCB_RAMP_LO 3
`define RCB_SEL_BIT 0
`define RCB_ONOFF_BIT 1
`define RCB_RX_BIT 2
`define RCB_ADR_IDX_HI 5
`define RCB_ADR_IDX_LO 2
`define RCB_ADR_TOP_LO 6
`define RCB_DATA_LANE 0
`define RCB_BR_HI 6
`define RCB_FIFO_SIZE_HI 7
`define RCB_FIFO_SIZE_LO 6
`define RCB_FIFO_LEVEL_HI 5
`define RCB_FIFO_LEVEL_LO 0
`define RCB_CTRL_MASK 8'h07
`define RCB_FULL_MASK 8'hFF
`define RCB_RST_OTHER 8'h00
`endif

// ---- pkg/rcb_pkg.sv ----
// Types shared by the radio configuration register bank.
package rcb_pkg;
	typedef logic [7:0] rcb_byte_t;
	typedef enum logic [1:0] {
		RCB_RAMP_3US,
		RCB_RAMP_8US5,
		RCB_RAMP_15US,
		RCB_RAMP_23US
	} rcb_ramp_e;
endpackage : rcb_pkg

// ---- hdl/rcb_reg_bank.sv ----
// Wishbone register bank holding the radio modem and synthesizer settings.
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/100ps
`include "rcb_cfg.svh"
module rcb_reg_bank
	import rcb_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone classic slave.
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [31:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic err_o,
	// Settings to the modem.
	output logic [6:0] bit_rate_divisor_o,
	output logic [7:0] onoff_floor_level_o,
	output logic onoff_floor_active_o,
	output logic [1:0] fifo_size_o,
	output logic [5:0] fifo_level_o,
	output rcb_ramp_e amp_ramp_time_o,
	// Selected synthesizer dividers.
	output logic divider_set_choice_o,
	output logic [7:0] ref_counter_o,
	output logic [7:0] prescale_counter_o,
	output logic [7:0] swallow_counter_o
);
	rcb_byte_t regs_q [`RCB_NUM_REGS];
	rcb_byte_t ctrl_q;
	logic ack_q;
	logic [31:0] dat_q;
	logic req;
	logic [3:0] idx;
	logic mapped;
	logic hit_ctrl;
	rcb_byte_t rd_byte;
	logic top_clear;
	logic hit_reg;
	logic wr_en;

	// A request is taken only while no ack stands, so a held strobe is never acknowledged in two cycles running.
	assign req = cyc_i && stb_i && !ack_q;
	// Word index is the byte address divided by four, since offsets are word multiples.
	assign idx = adr_i[`RCB_ADR_IDX_HI:`RCB_ADR_IDX_LO];
	// Any high address bit set means the access falls outside this bank.
	assign top_clear = (adr_i[31:`RCB_ADR_TOP_LO] == '0);
	assign hit_ctrl = top_clear && (idx == `RCB_IDX_CTRL);
	assign hit_reg = top_clear && (idx >= `RCB_FIRST_IDX) && (idx <= `RCB_IDX_RAMP);
	assign mapped = hit_reg || hit_ctrl;
	// A write lands only through byte lane 0, the lane that carries every field.
	assign wr_en = req && we_i && sel_i[`RCB_DATA_LANE];

	// One register per index; byte lane 0 carries all data.
	genvar g;
	for (g = 0; g < `RCB_NUM_REGS; g++) begin : g_reg
		localparam rcb_byte_t RST = (g == `RCB_IDX_BR) ? `RCB_RST_BR : (g == `RCB_IDX_FLOOR) ? `RCB_RST_FLOOR :
			(g == `RCB_IDX_FIFO) ? `RCB_RST_FIFO : (g == `RCB_IDX_PRE_B) ? `RCB_RST_PRE_B :
			(g == `RCB_IDX_RAMP) ? `RCB_RST_RAMP : `RCB_RST_OTHER;
		localparam rcb_byte_t MSK = (g == `RCB_IDX_BR) ? `RCB_BR_MASK : `RCB_FULL_MASK;
		if (g < `RCB_FIRST_IDX) begin : g_none
			// Indices below the bank hold no storage; they are unmapped, so the zero is never read out.
			always_ff @(posedge clk_i) begin
				regs_q[g] <= `RCB_RST_OTHER;
			end
		end else begin : g_live
			// Last written value is kept and read back; the bit-rate top bit stays zero.
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					regs_q[g] <= RST;
				end else if (wr_en && hit_reg && idx == 4'(g)) begin
					regs_q[g] <= dat_i[7:0] & MSK;
				end
			end
		end
	end

	// Reserved control bits are dropped on write so they always read back as zero.
	// Control register: divider select, on-off mode and receive state from software.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= `RCB_RST_CTRL;
		end else if (wr_en && hit_ctrl) begin
			ctrl_q <= dat_i[7:0] & `RCB_CTRL_MASK;
		end
	end

	// Read mux; the control word shows its live bits too.
	always_comb begin
		rd_byte = hit_ctrl ? ctrl_q : regs_q[(idx <= `RCB_IDX_RAMP) ? idx : '0];
	end

	// Ack or err one edge after the request; ack drops the next cycle, err repeats while the strobe is held.
	// Registering the answer costs a cycle but keeps ack free of address decode glitches.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			err_o <= 1'b0;
			dat_q <= 32'h00000000;
		end else begin
			ack_q <= req && mapped;
			err_o <= req && !mapped;
			dat_q <= (req && mapped && !we_i) ? {24'h000000, rd_byte} : 32'h00000000;
		end
	end
	assign ack_o = ack_q;
	assign dat_o = dat_q;

	// Field outputs.
	assign bit_rate_divisor_o = regs_q[`RCB_IDX_BR][`RCB_BR_HI:0];
	assign onoff_floor_level_o = regs_q[`RCB_IDX_FLOOR];
	// Floor only applies while receiving in on-off keying.
	assign onoff_floor_active_o = ctrl_q[`RCB_ONOFF_BIT] & ctrl_q[`RCB_RX_BIT];
	// FIFO size and level only pass through; the FIFO itself lives in another block.
	assign fifo_size_o = regs_q[`RCB_IDX_FIFO][`RCB_FIFO_SIZE_HI:`RCB_FIFO_SIZE_LO];
	assign fifo_level_o = regs_q[`RCB_IDX_FIFO][`RCB_FIFO_LEVEL_HI:`RCB_FIFO_LEVEL_LO];
	assign amp_ramp_time_o = rcb_ramp_e'(regs_q[`RCB_IDX_RAMP][`RCB_RAMP_HI:`RCB_RAMP_LO]);
	assign divider_set_choice_o = ctrl_q[`RCB_SEL_BIT];

	// Divider set mux; switching takes effect on the very next cycle.
	always_comb begin
		if (ctrl_q[`RCB_SEL_BIT]) begin
			ref_counter_o = regs_q[`RCB_IDX_REF_B];
			prescale_counter_o = regs_q[`RCB_IDX_PRE_B];
			swallow_counter_o = regs_q[`RCB_IDX_SWA_B];
		end else begin
			ref_counter_o = regs_q[`RCB_IDX_REF_A];
			prescale_counter_o = regs_q[`RCB_IDX_PRE_A];
			swallow_counter_o = regs_q[`RCB_IDX_SWA_A];
		end
	end

	// Reset values as seen in the first cycle after reset is released.
	property p_br_reset;
		@(posedge clk_i) $fell(rst_i) |-> bit_rate_divisor_o == 7'(`RCB_RST_BR);
	endproperty
	a_br_reset: assert property (p_br_reset) else $error("bit rate reset wrong");
	// The floor gate must never open outside on-off receive.
	property p_floor_gate;
		@(posedge clk_i) disable iff (rst_i) onoff_floor_active_o |-> ctrl_q[`RCB_RX_BIT] && ctrl_q[`RCB_ONOFF_BIT];
	endproperty
	a_floor_gate: assert property (p_floor_gate) else $error("floor active outside on-off receive");
	property p_floor_reset;
		@(posedge clk_i) $fell(rst_i) |-> onoff_floor_level_o == `RCB_RST_FLOOR;
	endproperty
	a_floor_reset: assert property (p_floor_reset) else $error("floor reset wrong");
	// With the choice set, all three counters must come from set B.
	property p_set_b;
		@(posedge clk_i) disable iff (rst_i) divider_set_choice_o |-> ref_counter_o == regs_q[`RCB_IDX_REF_B] &&
			prescale_counter_o == regs_q[`RCB_IDX_PRE_B] && swallow_counter_o == regs_q[`RCB_IDX_SWA_B];
	endproperty
	a_set_b: assert property (p_set_b) else $error("set B not applied");
	property p_ramp_reset;
		@(posedge clk_i) $fell(rst_i) |-> amp_ramp_time_o == RCB_RAMP_23US;
	endproperty
	a_ramp_reset: assert property (p_ramp_reset) else $error("ramp reset wrong");
	property p_set_a;
		@(posedge clk_i) $fell(rst_i) |-> !divider_set_choice_o && ref_counter_o == regs_q[`RCB_IDX_REF_A];
	endproperty
	a_set_a: assert property (p_set_a) else $error("set A not applied at reset");
	property p_readback;
		@(posedge clk_i) disable iff (rst_i)
			(wr_en && hit_reg && idx == `RCB_IDX_FLOOR) |=> onoff_floor_level_o == $past(dat_i[7:0]);
	endproperty
	a_readback: assert property (p_readback) else $error("write not stored");
	property p_ack_pulse;
		@(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
	// One answer per taken request, in the very next cycle, never both kinds at once.
	property p_answer_next;
		@(posedge clk_i) disable iff (rst_i) req |=> (ack_o ^ err_o);
	endproperty
	a_answer_next: assert property (p_answer_next) else $error("request not answered in the next cycle");
	// Read data stays zero outside an acknowledge so stale bytes never leak onto the bus.
	property p_rdata_idle;
		@(posedge clk_i) disable iff (rst_i) !ack_o |-> dat_o == '0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside acknowledge");
	// An unmapped access must leave the control word and bit rate as they were.
	property p_unmapped_safe;
		@(posedge clk_i) disable iff (rst_i) (req && !mapped) |=> $stable(ctrl_q) && $stable(bit_rate_divisor_o);
	endproperty
	a_unmapped_safe: assert property (p_unmapped_safe) else $error("unmapped access changed a register");
	// The reserved top bit of the bit-rate register can never hold a one.
	property p_br_top;
		@(posedge clk_i) disable iff (rst_i) (regs_q[`RCB_IDX_BR] & ~`RCB_BR_MASK) == '0;
	endproperty
	a_br_top: assert property (p_br_top) else $error("bit rate top bit set");
	// A write with lane 0 off is acknowledged but must not touch the floor level.
	property p_lane_off;
		@(posedge clk_i) disable iff (rst_i)
			(req && we_i && !sel_i[`RCB_DATA_LANE] && hit_reg && idx == `RCB_IDX_FLOOR) |=> $stable(onoff_floor_level_o);
	endproperty
	a_lane_off: assert property (p_lane_off) else $error("write without lane 0 stored");
	// A ramp write shows its code on the ramp output in the next cycle.
	property p_ramp_follow;
		@(posedge clk_i) disable iff (rst_i) (wr_en && hit_reg && idx == `RCB_IDX_RAMP) |=>
			amp_ramp_time_o == rcb_ramp_e'($past(dat_i[`RCB_RAMP_HI:`RCB_RAMP_LO]));
	endproperty
	a_ramp_follow: assert property (p_ramp_follow) else $error("ramp code not applied");
	// A control write sets the divider choice from its select bit.
	property p_sel_follow;
		@(posedge clk_i) disable iff (rst_i) (wr_en && hit_ctrl) |=> divider_set_choice_o == $past(dat_i[`RCB_SEL_BIT]);
	endproperty
	a_sel_follow: assert property (p_sel_follow) else $error("divider choice not applied");
	// The floor gate opens only after software has written both on-off mode and receiving.
	property p_floor_follow;
		@(posedge clk_i) disable iff (rst_i) (wr_en && hit_ctrl) |=>
			onoff_floor_active_o == ($past(dat_i[`RCB_ONOFF_BIT]) && $past(dat_i[`RCB_RX_BIT]));
	endproperty
	a_floor_follow: assert property (p_floor_follow) else $error("floor gate does not follow control");
	// Coverage of the main bus and mode scenarios.
	c_write: cover property (@(posedge clk_i) ack_o && we_i);
	c_read: cover property (@(posedge clk_i) ack_o && !we_i);
	c_sel_b: cover property (@(posedge clk_i) divider_set_choice_o);
	c_err: cover property (@(posedge clk_i) err_o);
endmodule : rcb_reg_bank

// ---- dv/rcb_reg_bank_bench.sv ----
// Self-checking bench for the radio configuration register bank.
`timescale 1ns/100ps
module rcb_reg_bank_bench import rcb_pkg::*;;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [31:0] adr_i = 32'h0;
	logic [31:0] dat_i = 32'h0;
	logic [3:0] sel_i = 4'hF;
	logic [3:0] sel_nxt = 4'hF;
	logic [31:0] dat_o;
	logic ack_o, err_o, onoff_floor_active_o, divider_set_choice_o, saw_err;
	logic [6:0] bit_rate_divisor_o;
	logic [7:0] onoff_floor_level_o, ref_counter_o, prescale_counter_o, swallow_counter_o;
	logic [1:0] fifo_size_o;
	logic [5:0] fifo_level_o;
	rcb_ramp_e amp_ramp_time_o;
	logic [7:0] m [16];
	logic [7:0] expq [$];
	int miscompares = 0, n_tests = 0, cycles = 0, seed = 32'hEEFA;
	rcb_reg_bank DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
		.bit_rate_divisor_o(bit_rate_divisor_o), .onoff_floor_level_o(onoff_floor_level_o),
		.onoff_floor_active_o(onoff_floor_active_o), .fifo_size_o(fifo_size_o), .fifo_level_o(fifo_level_o),
		.amp_ramp_time_o(amp_ramp_time_o), .divider_set_choice_o(divider_set_choice_o),
		.ref_counter_o(ref_counter_o), .prescale_counter_o(prescale_counter_o),
		.swallow_counter_o(swallow_counter_o));
	// Free-running 125 MHz clock.
	initial forever #4 clk_i = ~clk_i;
	// Compares one value and counts the outcome.
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Prints the counts and the verdict, then stops.
	task end_sim;
		$display("compared %0d, wrong %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim
	// One classic Wishbone cycle; a read notes the model's byte for the monitor.
	task wb(input logic w, input logic [3:0] idx, input logic [7:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= {26'h0, idx, 2'h0};
		dat_i <= {24'h0, d};
		sel_i <= sel_nxt;
		if (!w)
			expq.push_back(m[idx]);
		do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
		saw_err = err_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask : wb
	// Read data is judged at the acknowledge edge, oldest note first.
	always @(posedge clk_i) begin
		if (ack_o === 1'b1 && we_i === 1'b0 && expq.size() > 0)
			check(dat_o[7:0], expq.pop_front());
	end
	// A hung handshake counts as a mismatch; normal run takes under two hundred cycles.
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			miscompares++;
			end_sim();
		end
	end
	// Main sequence.
	initial begin
		m = '{3: 8'h07, 4: 8'h0C, 5: 8'h0F, 10: 8'h62, 12: 8'h38, default: 8'h00};
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 3; i < 16; i++)
			if (i < 13 || i == 15)
				wb(1'b0, 4'(i), 8'h00);
		check(8'(bit_rate_divisor_o), 8'h07);
		check(8'(amp_ramp_time_o), 8'h03);
		check(prescale_counter_o, 8'h00);
		$display("test reset values done");
		for (int i = 3; i < 13; i++) begin
			m[i] = 8'($random(seed));
			wb(1'b1, 4'(i), m[i]);
			if (i == 3)
				m[i][7] = 1'b0;
		end
		for (int i = 3; i < 13; i++)
			wb(1'b0, 4'(i), 8'h00);
		check(8'(bit_rate_divisor_o), m[3]);
		check(onoff_floor_level_o, m[4]);
		check(8'(amp_ramp_time_o), {6'h00, m[12][4:3]});
		check(8'(fifo_size_o), {6'h00, m[5][7:6]});
		check(8'(fifo_level_o), {2'h0, m[5][5:0]});
		// A write with lane 0 switched off is acknowledged and ignored.
		sel_nxt = 4'hE;
		wb(1'b1, 4'h4, ~m[4]);
		sel_nxt = 4'hF;
		wb(1'b0, 4'h4, 8'h00);
		check(onoff_floor_level_o, m[4]);
		$display("test readback done");
		// Every control code, so both divider sets and all mode pairs are seen.
		for (int c = 0; c < 8; c++) begin
			m[15] = 8'(c);
			wb(1'b1, 4'hF, m[15]);
			wb(1'b0, 4'hF, 8'h00);
			check(ref_counter_o, m[6 + 3 * (c % 2)]);
			check(prescale_counter_o, m[7 + 3 * (c % 2)]);
			check(swallow_counter_o, m[8 + 3 * (c % 2)]);
			check(8'(onoff_floor_active_o), 8'(c >= 6));
			check(8'(divider_set_choice_o), 8'(c % 2));
		end
		$display("test divider select done");
		// A second reset in mid-run must bring back the reset settings.
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check(8'(bit_rate_divisor_o), 8'h07);
		check(8'(amp_ramp_time_o), 8'h03);
		check(8'(divider_set_choice_o), 8'h00);
		check(8'(onoff_floor_active_o), 8'h00);
		$display("test mid-run reset done");
		wb(1'b1, 4'h0, 8'hFF);
		check(8'(saw_err), 8'h01);
		wb(1'b1, 4'hD, 8'hFF);
		check(8'(saw_err), 8'h01);
		$display("test unmapped done");
		end_sim();
	end
endmodule : rcb_reg_bank_bench
